// File: core/cst_pkg.sv
// Constants and types for the charger supervisor timers
package cst_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // Slow timer tick period
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);
    localparam int unsigned WDOG_S = 30;
    localparam logic [23:0] WDOG_TICKS = 24'(WDOG_S * 1000_000 / TICK_US);
    localparam int unsigned SAFE_DEFAULT_MIN = 27;
    localparam logic [23:0] SAFE_DEFAULT_TICKS = 24'(SAFE_DEFAULT_MIN * 60 * 1000_000 / TICK_US);
    // Status pulse width
    localparam int unsigned PULSE_US = 128;
    localparam logic [15:0] PULSE_CYC = 16'((CLK_HZ / 1_000_000) * PULSE_US);
    // Short-circuit retry deglitch
    localparam int unsigned DEGLITCH_US = 64;
    localparam logic [15:0] DEGLITCH_CYC = 16'((CLK_HZ / 1_000_000) * DEGLITCH_US);
    // Fault field codes
    localparam logic [2:0] FLT_NORMAL = 3'h0;
    localparam logic [2:0] FLT_THERMAL = 3'h1;
    localparam logic [2:0] FLT_BATTEMP = 3'h2;
    localparam logic [2:0] FLT_WDOG = 3'h3;
    localparam logic [2:0] FLT_SAFETY = 3'h4;
    localparam logic [2:0] FLT_SUPPLY = 3'h5;
    localparam logic [2:0] FLT_BATTERY = 3'h7;
    // Temperature status normal code
    localparam logic [1:0] TEMP_NORMAL = 2'h0;
    // Fallback register defaults, in register units
    localparam logic [5:0] DEF_VREG = 6'h05;
    localparam logic [4:0] DEF_ICHG = 5'h04;
    localparam logic [2:0] DEF_ILIM = 3'h4;
    localparam logic DEF_CHG_DIS = 1'b0;
    localparam logic DEF_HIZ = 1'b0;
    localparam logic DEF_TERM_EN = 1'b1;
    localparam logic [1:0] DEF_TMR_SEL = 2'h1;
    typedef enum logic [2:0] {
        CST_SC_ON = 3'b001,
        CST_SC_OFF = 3'b010,
        CST_SC_IDLE = 3'b100
    } cst_sc_e;
endpackage

// File: core/cst_sync.sv
// Two-flop synchroniser bank
module cst_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// File: core/cst_top.sv
// Charger supervisor: watchdog, safety timer, fallback mode and fault reactions
// What this block does
// RULE1 - Battery overvoltage stops converter, FET on, flags
// RULE2 - Battery-only: FET on, short retries after deglitch
// RULE3 - Battery under lockout keeps FET off
// RULE4 - Discharge gate on: no input, high-Z, disable
// RULE5 - Fallback on low battery, watchdog, early fault exit
// RULE6 - Fallback reloads defaults, restarts safety timer
// RULE7 - Defaults: 3.6V, 1A, 1.5A
// RULE8 - Any host register write leaves fallback
// RULE9 - Terminated charge not restarted by fallback
// RULE10 - Safety expiry halts, disables charge, pulses
// RULE11 - Safety fault cleared by toggling charge-disable
// RULE12 - Changing timer duration resets safety count
// RULE13 - First host access starts 30 s watchdog
// RULE14 - Kick bit restarts watchdog, self-clears
// RULE15 - Watchdog expiry enters fallback, keeps charging
// RULE16 - Disable pin high: no charge, high-Z
// RULE17 - Disable pin high resets safety timer
// RULE18 - Gate regulator on with input present unless lockout, sleep, thermal
// RULE19 - Thermistor monitor off reports normal temperature
// RULE20 - Thermal shutdown suspends, freezes timers, pulses
// RULE21 - Sleep: converter off, FET on, gate low, pulse
// RULE22 - Sleep exit clears status, new charge cycle
// RULE23 - Three-bit fault field encoding
// RULE24 - Charge-disable bit: 1 disables, resets 0
// RULE25 - Timers count a fixed slow tick
module cst_top
    import cst_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_disable_pin,
    input wire logic input_present,
    input wire logic input_uvlo,
    input wire logic input_below_sleep,
    input wire logic bat_ovp,
    input wire logic bat_above_uvlo,
    input wire logic bat_below_3v6,
    input wire logic bat_short,
    input wire logic thermal_hot,
    input wire logic thermal_cool,
    input wire logic [1:0] therm_status_raw,
    input wire logic charge_terminated,
    input wire logic host_access,
    input wire logic host_wr,
    input wire logic wr_kick,
    input wire logic wr_chg_dis,
    input wire logic wr_hiz,
    input wire logic wr_term_en,
    input wire logic wr_therm_en,
    input wire logic [1:0] wr_tmr_sel,
    input wire logic [5:0] wr_vreg,
    input wire logic [4:0] wr_ichg,
    input wire logic [2:0] wr_ilim,
    output logic converter_en,
    output logic battery_fet_on,
    output logic discharge_gate_drive,
    output logic gate_driver_regulator,
    output logic charging,
    output logic status_pulse,
    output logic [2:0] fault_code,
    output logic [1:0] temp_status,
    output logic bat_ovp_flag,
    output logic fallback_mode,
    output logic watchdog_kick_bit,
    output logic chg_dis_bit,
    output logic high_impedance_mode_bit,
    output logic term_en_bit,
    output logic [1:0] tmr_sel_bit,
    output logic [5:0] vreg_set,
    output logic [4:0] ichg_set,
    output logic [2:0] ilim_set
);
    import cst_pkg::*;

    localparam int NS = 10;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] s_in;
    assign raw_in = {chip_disable_pin, input_present, input_uvlo, input_below_sleep, bat_ovp,
                     bat_above_uvlo, bat_below_3v6, bat_short, thermal_hot, thermal_cool};
    cst_sync #(.W(NS)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(raw_in),
        .sync_out(s_in)
    );
    logic dis_pin_s, vin_s, uvlo_s, slp_s, bovp_s, bok_s, blow_s, bsc_s, hot_s, cool_s;
    assign {dis_pin_s, vin_s, uvlo_s, slp_s, bovp_s, bok_s, blow_s, bsc_s, hot_s, cool_s} = s_in;

    // Register file and control bits
    logic kick_q, chg_dis_q, hiz_q, term_q, therm_en_q, fb_q, host_seen_q;
    logic [1:0] tmr_sel_q;
    logic [5:0] vreg_q;
    logic [4:0] ichg_q;
    logic [2:0] ilim_q;
    logic enter_fb, safety_exp, wdog_exp;
    logic safety_flt_q, tsd_q, sleep_q, dis_pin_q, fault_any_q;

    // Fallback entry: conditions evaluated each cycle
    logic fault_exit;
    assign fault_exit = fault_any_q && !(tsd_q || sleep_q || bovp_s);
    assign enter_fb = !fb_q && ((!host_seen_q && !chg_dis_q && blow_s) // [RULE5]
                              || (wdog_exp && !safety_flt_q)           // [RULE5] [RULE15]
                              || (!host_seen_q && fault_exit));        // [RULE5]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fb_q <= 1'b0;
        end else if (enter_fb) begin
            fb_q <= 1'b1;
        end else if (host_wr) begin
            fb_q <= 1'b0; // [RULE8]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || enter_fb) begin
            // Defaults reload on fallback entry [RULE6] [RULE7] [RULE24]
            chg_dis_q <= DEF_CHG_DIS;
            hiz_q <= DEF_HIZ;
            term_q <= DEF_TERM_EN;
            therm_en_q <= 1'b1;
            tmr_sel_q <= DEF_TMR_SEL;
            vreg_q <= DEF_VREG;
            ichg_q <= DEF_ICHG;
            ilim_q <= DEF_ILIM;
        end else if (safety_exp) begin
            chg_dis_q <= 1'b1; // [RULE10]
        end else if (host_wr) begin
            chg_dis_q <= wr_chg_dis;
            hiz_q <= wr_hiz;
            term_q <= wr_term_en;
            therm_en_q <= wr_therm_en;
            tmr_sel_q <= wr_tmr_sel;
            vreg_q <= wr_vreg;
            ichg_q <= wr_ichg;
            ilim_q <= wr_ilim;
        end
    end

    // Kick bit: set by host, cleared once watchdog restarted
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kick_q <= 1'b0;
        end else if (host_wr && wr_kick) begin
            kick_q <= 1'b1;
        end else if (kick_q) begin
            kick_q <= 1'b0; // [RULE14]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_seen_q <= 1'b0;
        end else if (host_access) begin
            host_seen_q <= 1'b1; // [RULE13]
        end
    end

    // Slow tick shared by both timers; frozen in thermal shutdown
    logic [16:0] tick_cnt_q;
    logic tick;
    assign tick = (tick_cnt_q == TICK_LAST) && !tsd_q; // [RULE25] [RULE20]
    always_ff @(posedge clk) begin
        if (sys_rst || tick_cnt_q == TICK_LAST) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h1;
        end
    end

    // Watchdog
    logic [23:0] wdog_cnt_q;
    logic wdog_run_q;
    assign wdog_exp = wdog_run_q && (wdog_cnt_q == WDOG_TICKS);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdog_run_q <= 1'b0;
            wdog_cnt_q <= '0;
        end else if (wdog_exp) begin
            wdog_run_q <= 1'b0;
            wdog_cnt_q <= '0;
        end else if ((host_access && !host_seen_q) || kick_q) begin
            wdog_run_q <= 1'b1; // [RULE13] [RULE14]
            wdog_cnt_q <= '0;
        end else if (wdog_run_q && tick) begin
            wdog_cnt_q <= wdog_cnt_q + 24'h1; // [RULE25]
        end
    end

    // Safety timer; length scales with selection, default 27 min
    logic [23:0] safe_cnt_q, safe_limit;
    logic chg_active;
    always_comb begin
        case (tmr_sel_q)
            2'h0: safe_limit = SAFE_DEFAULT_TICKS >> 1;
            2'h1: safe_limit = SAFE_DEFAULT_TICKS;
            2'h2: safe_limit = SAFE_DEFAULT_TICKS << 1;
            default: safe_limit = 24'hffffff;
        endcase
    end
    assign safety_exp = chg_active && !charge_terminated && (safe_cnt_q == safe_limit);
    logic sel_change;
    assign sel_change = host_wr && (wr_tmr_sel != tmr_sel_q);
    always_ff @(posedge clk) begin
        if (sys_rst || enter_fb || sel_change || (dis_pin_s && !dis_pin_q)) begin
            safe_cnt_q <= '0; // [RULE6] [RULE12] [RULE17]
        end else if (chg_active && tick && safe_cnt_q != safe_limit) begin
            safe_cnt_q <= safe_cnt_q + 24'h1; // [RULE10]
        end
    end

    // Safety fault cleared on a charge-disable toggle; expiry wins
    logic chg_dis_prev_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            safety_flt_q <= 1'b0;
            chg_dis_prev_q <= 1'b0;
        end else begin
            chg_dis_prev_q <= chg_dis_q;
            if (safety_exp) begin
                safety_flt_q <= 1'b1;
            end else if (chg_dis_prev_q && !chg_dis_q) begin
                safety_flt_q <= 1'b0; // [RULE11]
            end
        end
    end

    // Thermal shutdown with hysteresis from the cool comparator
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tsd_q <= 1'b0;
        end else if (hot_s) begin
            tsd_q <= 1'b1; // [RULE20]
        end else if (cool_s) begin
            tsd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_q <= 1'b0;
            dis_pin_q <= 1'b0;
        end else begin
            sleep_q <= vin_s && !uvlo_s && slp_s; // [RULE21] [RULE22]
            dis_pin_q <= dis_pin_s;
        end
    end

    // Charging permission; terminated cycles stay done across fallback
    logic hiz_any;
    assign hiz_any = hiz_q || dis_pin_s; // [RULE16]
    logic term_done_q;
    always_ff @(posedge clk) begin
        if (sys_rst || sleep_q || !vin_s) begin
            term_done_q <= 1'b0; // [RULE22]
        end else if (term_q && charge_terminated) begin
            term_done_q <= 1'b1; // [RULE9]
        end
    end
    assign chg_active = vin_s && !hiz_any && !chg_dis_q && !safety_flt_q && !tsd_q && !sleep_q
                        && !bovp_s && !term_done_q;

    // Battery-only short-circuit retry
    cst_sc_e sc_q;
    logic [15:0] sc_cnt_q;
    always_ff @(posedge clk) begin
        if (sys_rst || vin_s || !bok_s) begin
            sc_q <= CST_SC_IDLE; // [RULE3]
            sc_cnt_q <= '0;
        end else begin
            case (sc_q)
                CST_SC_IDLE: sc_q <= CST_SC_ON; // [RULE2]
                CST_SC_ON: begin
                    if (bsc_s) begin
                        sc_q <= CST_SC_OFF;
                        sc_cnt_q <= '0;
                    end
                end
                CST_SC_OFF: begin
                    if (sc_cnt_q == DEGLITCH_CYC - 16'h1) begin
                        sc_q <= CST_SC_ON; // [RULE2]
                    end else begin
                        sc_cnt_q <= sc_cnt_q + 16'h1;
                    end
                end
                default: sc_q <= CST_SC_IDLE;
            endcase
        end
    end

    // Fault field with priority; events give one status pulse
    logic [2:0] fault_d;
    always_comb begin
        if (tsd_q) fault_d = FLT_THERMAL; // [RULE23]
        else if (bovp_s) fault_d = FLT_BATTERY;
        else if (sleep_q) fault_d = FLT_SUPPLY;
        else if (safety_flt_q) fault_d = FLT_SAFETY;
        else if (wdog_exp) fault_d = FLT_WDOG;
        else if (therm_en_q && therm_status_raw != TEMP_NORMAL) fault_d = FLT_BATTEMP;
        else if (fault_code == FLT_WDOG && fb_q) fault_d = FLT_WDOG;
        else fault_d = FLT_NORMAL;
    end

    logic [15:0] pulse_cnt_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_code <= FLT_NORMAL;
            fault_any_q <= 1'b0;
            pulse_cnt_q <= '0;
            status_pulse <= 1'b0;
        end else begin
            fault_code <= fault_d;
            fault_any_q <= tsd_q || sleep_q || bovp_s;
            // Any new fault code other than FLT_NORMAL retriggers one pulse [RULE10] [RULE20] [RULE21]
            if (fault_d != fault_code && fault_d != FLT_NORMAL) begin
                pulse_cnt_q <= PULSE_CYC - 16'h1;
                status_pulse <= 1'b1;
            end else if (pulse_cnt_q != 16'h0) begin
                pulse_cnt_q <= pulse_cnt_q - 16'h1;
            end else begin
                status_pulse <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            converter_en <= 1'b0;
            battery_fet_on <= 1'b0;
            discharge_gate_drive <= 1'b0;
            gate_driver_regulator <= 1'b0;
            charging <= 1'b0;
            temp_status <= TEMP_NORMAL;
            bat_ovp_flag <= 1'b0;
        end else begin
            converter_en <= vin_s && !hiz_any && !tsd_q && !sleep_q && !bovp_s; // [RULE1] [RULE20] [RULE21]
            if (!bok_s) begin
                battery_fet_on <= 1'b0; // [RULE3]
            end else if (!vin_s) begin
                battery_fet_on <= (sc_q == CST_SC_ON); // [RULE2]
            end else begin
                battery_fet_on <= bovp_s || sleep_q || hiz_any || chg_active; // [RULE1] [RULE21]
            end
            discharge_gate_drive <= (!vin_s || hiz_q || dis_pin_s) && !sleep_q; // [RULE4] [RULE21]
            gate_driver_regulator <= vin_s && !uvlo_s && !slp_s && !tsd_q; // [RULE18]
            charging <= chg_active;
            temp_status <= therm_en_q ? therm_status_raw : TEMP_NORMAL; // [RULE19]
            bat_ovp_flag <= bovp_s; // [RULE1]
        end
    end

    assign fallback_mode = fb_q;
    assign watchdog_kick_bit = kick_q;
    assign chg_dis_bit = chg_dis_q;
    assign high_impedance_mode_bit = hiz_q;
    assign term_en_bit = term_q;
    assign tmr_sel_bit = tmr_sel_q;
    assign vreg_set = vreg_q;
    assign ichg_set = ichg_q;
    assign ilim_set = ilim_q;
endmodule

// File: test/cst_chk.sv
// Port-level checks for the supervisor timers
module cst_chk
    import cst_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_disable_pin,
    input wire logic input_present,
    input wire logic input_uvlo,
    input wire logic input_below_sleep,
    input wire logic bat_ovp,
    input wire logic bat_above_uvlo,
    input wire logic thermal_hot,
    input wire logic host_wr,
    input wire logic wr_kick,
    input wire logic converter_en,
    input wire logic battery_fet_on,
    input wire logic discharge_gate_drive,
    input wire logic gate_driver_regulator,
    input wire logic charging,
    input wire logic status_pulse,
    input wire logic [2:0] fault_code,
    input wire logic bat_ovp_flag,
    input wire logic fallback_mode,
    input wire logic watchdog_kick_bit,
    input wire logic high_impedance_mode_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pulse_cnt_q;
    // Width judged at the fall, since a retrigger may stretch it
    always_ff @(posedge clk) begin
        if (sys_rst || !status_pulse) begin
            pulse_cnt_q <= 16'h0;
        end else begin
            pulse_cnt_q <= pulse_cnt_q + 16'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Pins pass a synchroniser, so causes are held five cycles
    a_kick_pulse: assert property (host_wr && wr_kick ##1 !(host_wr && wr_kick) |-> watchdog_kick_bit ##1 !watchdog_kick_bit)
        else $error("kick bit not a one cycle pulse");
    a_gate_idle: assert property ((!input_present && !input_below_sleep)[*5] |=> discharge_gate_drive)
        else $error("gate off without input");
    a_gate_disable: assert property ((chip_disable_pin && !input_below_sleep)[*5] |=> discharge_gate_drive && !charging)
        else $error("disable pin ignored");
    a_gate_hiz: assert property ((high_impedance_mode_bit && !input_below_sleep)[*5] |=> discharge_gate_drive)
        else $error("gate off in high impedance mode");
    a_uvlo_fet: assert property ((!input_present && !bat_above_uvlo)[*5] |=> !battery_fet_on)
        else $error("fet on with battery under lockout");
    a_ovp_react: assert property (bat_ovp[*5] |=> bat_ovp_flag && !converter_en && battery_fet_on)
        else $error("battery over-voltage not handled");
    a_thermal_stop: assert property (thermal_hot[*5] |=> !converter_en && !charging && fault_code == FLT_THERMAL)
        else $error("thermal shutdown not handled");
    a_regulator_off: assert property ((input_uvlo || input_below_sleep || thermal_hot || !input_present)[*5] |=> !gate_driver_regulator)
        else $error("gate regulator left on");
    a_pulse_width: assert property ($fell(status_pulse) |-> pulse_cnt_q >= PULSE_CYC)
        else $error("status pulse too short");
    a_write_exits: assert property (host_wr |=> !fallback_mode)
        else $error("write did not leave fallback");
    a_fault_legal: assert property (fault_code != 3'h6)
        else $error("unused fault code shown");
endmodule
bind cst_top cst_chk i_chk (.clk, .sys_rst, .chip_disable_pin, .input_present, .input_uvlo, .input_below_sleep,
    .bat_ovp, .bat_above_uvlo, .thermal_hot, .host_wr, .wr_kick, .converter_en, .battery_fet_on,
    .discharge_gate_drive, .gate_driver_regulator, .charging, .status_pulse, .fault_code, .bat_ovp_flag,
    .fallback_mode, .watchdog_kick_bit, .high_impedance_mode_bit);

// File: test/cst_host.sv
// Host processor model issuing whole-image register writes
module cst_host (
    input wire logic clk,
    output logic host_access,
    output logic host_wr,
    output logic [20:0] img
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        host_access = 1'b0;
        host_wr = 1'b0;
        img = 21'h0;
    end
    // Any write regains control; kick and charge-disable ride in the image
    task automatic put(input logic [20:0] v);
        @(posedge clk);
        #1;
        img = v;
        host_access = 1'b1;
        host_wr = 1'b1;
        @(posedge clk);
        #1;
        host_access = 1'b0;
        host_wr = 1'b0;
        // Stale data must not look like the last image
        img = ~v;
    endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the supervisor timers
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cst_pkg::*;
    typedef struct {int s; logic [7:0] e;} cst_note_s;
    localparam int CONV = 0, FET = 1, GATE = 2, REG = 3, CHG = 4, PUL = 5, FLT = 6, TMP = 7, OVP = 8;
    localparam int FB = 9, KICK = 10, DIS = 11, VREG = 12, ICHG = 13, ILIM = 14, SEL = 15;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic chip_disable_pin = 1'b0, input_uvlo = 1'b0, input_below_sleep = 1'b0, bat_ovp = 1'b0;
    logic input_present = 1'b1, bat_above_uvlo = 1'b1, thermal_cool = 1'b1, bat_short = 1'b0;
    logic thermal_hot = 1'b0, bat_below_3v6 = 1'b0, charge_terminated = 1'b0;
    logic [1:0] therm_status_raw = 2'h0;
    logic host_access, host_wr, converter_en, battery_fet_on, discharge_gate_drive, gate_driver_regulator;
    logic charging, status_pulse, bat_ovp_flag, fallback_mode, watchdog_kick_bit, chg_dis_bit;
    logic high_impedance_mode_bit, term_en_bit;
    logic [20:0] img, v;
    logic [2:0] fault_code, ilim_set;
    logic [1:0] temp_status, tmr_sel_bit;
    logic [5:0] vreg_set;
    logic [4:0] ichg_set;
    logic [15:0] rnd = 16'h0063;
    logic [7:0] ob [16];
    string nm [16] = '{"conv", "fet", "gate", "regulator", "charging", "pulse", "fault", "temp", "ovp", "fallback",
        "kick", "chg_dis", "vreg", "ichg", "ilim", "tmr_sel"};
    cst_note_s notes [$];
    int fail_count = 0;
    int comparisons = 0;
    assign ob = '{8'(converter_en), 8'(battery_fet_on), 8'(discharge_gate_drive), 8'(gate_driver_regulator),
        8'(charging), 8'(status_pulse), 8'(fault_code), 8'(temp_status), 8'(bat_ovp_flag), 8'(fallback_mode),
        8'(watchdog_kick_bit), 8'(chg_dis_bit), 8'(vreg_set), 8'(ichg_set), 8'(ilim_set), 8'(tmr_sel_bit)};
    cst_host i_cst_host (.clk, .host_access, .host_wr, .img);
    cst_top i_cst_top (.clk, .sys_rst, .chip_disable_pin, .input_present, .input_uvlo, .input_below_sleep,
        .bat_ovp, .bat_above_uvlo, .bat_below_3v6, .bat_short, .thermal_hot, .thermal_cool, .therm_status_raw,
        .charge_terminated, .host_access, .host_wr, .wr_kick(img[20]), .wr_chg_dis(img[19]), .wr_hiz(img[18]),
        .wr_term_en(img[17]), .wr_therm_en(img[16]), .wr_tmr_sel(img[15:14]), .wr_vreg(img[13:8]),
        .wr_ichg(img[7:3]), .wr_ilim(img[2:0]), .converter_en, .battery_fet_on, .discharge_gate_drive,
        .gate_driver_regulator, .charging, .status_pulse, .fault_code, .temp_status, .bat_ovp_flag,
        .fallback_mode, .watchdog_kick_bit, .chg_dis_bit, .high_impedance_mode_bit, .term_en_bit,
        .tmr_sel_bit, .vreg_set, .ichg_set, .ilim_set);
    always #5 clk = ~clk;
    function automatic logic [20:0] mk(input logic [4:0] f);
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return {f, rnd};
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic want(input int s, input logic [7:0] e);
        notes.push_back('{s, e});
    endtask
    task automatic cmp(input int s, input logic [7:0] e);
        comparisons++;
        if (ob[s] !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm[s], e, ob[s]);
        end
    endtask
    // Notes are settled by the negedge after they were taken
    always @(negedge clk) begin
        while (notes.size() > 0) begin
            cmp(notes[0].s, notes[0].e);
            void'(notes.pop_front());
        end
    end
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_for(input int s, input logic [7:0] e, input int lim);
        int k = 0;
        while (ob[s] !== e && k < lim) begin
            step(1);
            k++;
        end
        if (ob[s] !== e) begin
            cmp(s, e);
            conclude();
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        step(3);
        want(DIS, 8'h0);
        want(FB, 8'h0);
        want(KICK, 8'h0);
        want(VREG, 8'(DEF_VREG));
        want(ICHG, 8'(DEF_ICHG));
        want(ILIM, 8'(DEF_ILIM));
        $display("test reset done");
        bat_below_3v6 = 1'b1;
        wait_for(FB, 8'h1, 20);
        want(VREG, 8'(DEF_VREG));
        v = mk(5'b00011);
        i_cst_host.put(v);
        want(FB, 8'h0);
        want(VREG, 8'(v[13:8]));
        want(ICHG, 8'(v[7:3]));
        want(ILIM, 8'(v[2:0]));
        want(SEL, 8'(v[15:14]));
        step(5);
        want(FB, 8'h0);
        bat_below_3v6 = 1'b0;
        i_cst_host.put(mk(5'b10011));
        want(KICK, 8'h1);
        step(1);
        want(KICK, 8'h0);
        $display("test fallback and kick done");
        for (int i = 0; i < 4; i++) begin
            input_present = (i != 1);
            chip_disable_pin = (i == 3);
            i_cst_host.put(mk({2'b00, i == 2, 2'b11}));
            step(4);
            want(GATE, 8'(i != 0));
            want(CHG, 8'(i == 0));
        end
        input_present = 1'b1;
        chip_disable_pin = 1'b0;
        i_cst_host.put(mk(5'b00011));
        $display("test discharge gate done");
        input_present = 1'b0;
        step(4);
        want(FET, 8'h1);
        want(REG, 8'h0);
        bat_short = 1'b1;
        wait_for(FET, 8'h0, 10);
        wait_for(FET, 8'h1, int'(DEGLITCH_CYC) + 20);
        wait_for(FET, 8'h0, 10);
        bat_short = 1'b0;
        wait_for(FET, 8'h1, int'(DEGLITCH_CYC) + 20);
        bat_above_uvlo = 1'b0;
        // Held past the checker's five-cycle window
        step(6);
        want(FET, 8'h0);
        bat_above_uvlo = 1'b1;
        input_present = 1'b1;
        input_uvlo = 1'b1;
        step(4);
        want(REG, 8'h0);
        input_uvlo = 1'b0;
        step(4);
        want(REG, 8'h1);
        $display("test battery only done");
        wait_for(PUL, 8'h0, 13000);
        input_below_sleep = 1'b1;
        step(4);
        want(CONV, 8'h0);
        want(FET, 8'h1);
        want(GATE, 8'h0);
        want(PUL, 8'h1);
        input_below_sleep = 1'b0;
        step(4);
        want(FLT, 8'(FLT_NORMAL));
        want(CHG, 8'h1);
        $display("test sleep done");
        wait_for(PUL, 8'h0, 13000);
        thermal_hot = 1'b1;
        thermal_cool = 1'b0;
        step(6);
        want(FLT, 8'(FLT_THERMAL));
        want(PUL, 8'h1);
        want(CONV, 8'h0);
        want(REG, 8'h0);
        thermal_hot = 1'b0;
        step(4);
        want(CHG, 8'h0);
        thermal_cool = 1'b1;
        step(4);
        want(CHG, 8'h1);
        bat_ovp = 1'b1;
        step(6);
        want(OVP, 8'h1);
        want(CONV, 8'h0);
        want(FET, 8'h1);
        want(FLT, 8'(FLT_BATTERY));
        bat_ovp = 1'b0;
        step(4);
        $display("test faults done");
        i_cst_host.put(mk(5'b00010));
        therm_status_raw = rnd[1:0] | 2'h1;
        step(1);
        want(TMP, 8'(TEMP_NORMAL));
        i_cst_host.put(mk(5'b01010));
        want(DIS, 8'h1);
        step(4);
        want(CHG, 8'h0);
        i_cst_host.put(mk(5'b00010));
        step(4);
        want(CHG, 8'h1);
        i_cst_host.put(mk(5'b00011));
        step(2);
        want(TMP, 8'(therm_status_raw));
        want(FLT, 8'(FLT_BATTEMP));
        // Termination must stick after the level drops
        charge_terminated = 1'b1;
        step(2);
        charge_terminated = 1'b0;
        step(2);
        want(CHG, 8'h0);
        $display("test control bits done");
        step(2);
        conclude();
    end
endmodule
